//--- design/spmc_pkg.sv
// Shared constants and bus carriers of the serial port mode control block
package spmc_pkg;

    // ************************************************
    // Register bus geometry
    // ************************************************
    localparam int ADDR_W = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************************************************
    // Register byte offsets
    // ************************************************
    localparam logic [7:0] OFS_SERIAL_CONTROL_STATUS = 8'h00;
    localparam logic [7:0] OFS_SERIAL_DATA_BUFFER = 8'h04;
    localparam logic [7:0] OFS_POWER_CONTROL = 8'h08;
    localparam logic [7:0] OFS_BAUD_PERIOD = 8'h0c;
    localparam logic [7:0] OFS_INT_STATUS = 8'h10;
    localparam logic [7:0] OFS_INT_ENABLE = 8'h14;
    localparam logic [7:0] OFS_INT_CLEAR = 8'h18;

    // ************************************************
    // Field positions of serial_control_status
    // ************************************************
    localparam int BIT_RECEIVE_DONE = 0;
    localparam int BIT_TRANSMIT_DONE = 1;
    localparam int BIT_RECEIVE_NINTH = 2;
    localparam int BIT_TRANSMIT_NINTH = 3;
    localparam int BIT_RECEIVE_ENABLE = 4;
    localparam int BIT_MULTIPROCESSOR = 5;
    localparam int BIT_MODE_LOW = 6;
    localparam int BIT_MODE_HIGH = 7;

    // ************************************************
    // Field positions of power_control and interrupt registers
    // ************************************************
    localparam int BIT_FE_ACCESS_SELECT = 6;
    localparam int BIT_BAUD_DOUBLER = 7;
    localparam logic [7:0] POWER_CONTROL_MASK = 8'hc0;
    localparam int INT_TRANSMIT = 0;
    localparam int INT_RECEIVE = 1;
    localparam int INT_FRAMING = 2;

    // ************************************************
    // Reset values and timing counts in clock cycles
    // ************************************************
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] POWER_CONTROL_RST = 8'h00;
    localparam logic [15:0] BAUD_PERIOD_RST = 16'h00a0;
    localparam logic [15:0] SHIFT_MODE_DIV = 16'h0006;
    localparam logic [15:0] FIXED_MODE_DIV_SLOW = 16'h0020;
    localparam logic [15:0] FIXED_MODE_DIV_FAST = 16'h0010;

    // ************************************************
    // Mode encodings of the two mode-select bits
    // ************************************************
    localparam logic [1:0] MODE_SHIFT = 2'h0;
    localparam logic [1:0] MODE_UART8_VAR = 2'h1;
    localparam logic [1:0] MODE_UART9_FIXED = 2'h2;
    localparam logic [1:0] MODE_UART9_VAR = 2'h3;

    // ************************************************
    // AXI4-Lite carriers
    // ************************************************
    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } spmc_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } spmc_axi_rsp_s;

endpackage

//--- design/spmc_rx_sync.sv
// Three-stage synchroniser with agreement filter for the receive pin
`timescale 1ns/1ps
module spmc_rx_sync (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Pin and filtered level
    input wire logic pin_in,
    output logic level_out
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } spmc_sync_s;

    spmc_sync_s st_r;
    spmc_sync_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = pin_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        // Only a level seen by both later stages counts
        if (st_r.s2 == st_r.s3) begin
            st_nxt.lvl = st_r.s3;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= 4'hf;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level_out = st_r.lvl;

endmodule // spmc_rx_sync

//--- design/spmc_serial_port.sv
// Serial port mode control: register file, frame engines and interrupt
// Contract
// - Top control bit shows high mode select only while framing access select is 0.
// - Mode bits pick shift clock/6, 8-bit variable, 9-bit clock/32 or /16, 9-bit variable.
// - Nine-bit modes with multiprocessor enable: no receive flag when ninth bit is 0.
// - Eight-bit variable mode with multiprocessor enable: no receive flag without valid stop.
// - Receive enable gates reception; cleared enable stops accepting new data.
// - Nine-bit modes send the transmit ninth bit as ninth data bit.
// - Nine-bit modes store received ninth bit; shift mode leaves that field alone.
// - Eight-bit mode without multiprocessor enable stores the stop bit as ninth bit.
// - Transmit flag sets after eighth shift bit or at stop start; software clears it.
// - Receive flag stays set until software clears it; hardware never clears it.
// - With framing access selected top bit reads the sticky framing error flag.
// - Eight-bit frames carry start 0, eight data bits LSB first, stop 1.
// - Nine-bit frames add the ninth bit before stop; both nine-bit modes ignore stop for the receive flag.
// - Data buffer write starts transmit; receive starts per mode while enabled. In shift mode a write during a running receive is ignored.
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
module spmc_serial_port (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire spmc_pkg::spmc_axi_req_s axi_req,
    output spmc_pkg::spmc_axi_rsp_s axi_rsp,
    // Serial pins, receive pin is two-way in shift-register mode
    input wire logic rxd_in,
    output logic rxd_out,
    output logic rxd_oe_n,
    output logic txd,
    // Interrupt
    output logic irq
);

    // ************************************************
    // State
    // ************************************************
    typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} spmc_tx_e;
    typedef enum logic [2:0] {RX_IDLE = 3'b001, RX_START = 3'b010, RX_DATA = 3'b100} spmc_rx_e;

    typedef struct packed {
        spmc_pkg::spmc_axi_rsp_s rsp;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [7:0] ctl;
        logic fe;
        logic [7:0] power_control;
        logic [15:0] baud;
        logic [7:0] rx_buf;
        logic [2:0] istat;
        logic [2:0] ien;
        logic irq;
        spmc_tx_e tx_st;
        logic [10:0] tx_sh;
        logic [3:0] tx_idx;
        logic [15:0] tx_cyc;
        spmc_rx_e rx_st;
        logic [7:0] rx_sh;
        logic rx_ninth;
        logic [3:0] rx_idx;
        logic [15:0] rx_cyc;
        logic rx_prev;
        logic txd;
        logic rxd_out;
        logic rxd_oe_n;
    } spmc_state_s;

    spmc_state_s st_r;
    spmc_state_s st_nxt;
    logic rx_lvl;

    // ************************************************
    // Helpers
    // ************************************************
    // Bit time in clocks; the variable rate stands in for the external timer
    function automatic logic [15:0] bit_period(logic [1:0] mode, logic dbl, logic [15:0] var_per);
        logic [15:0] p;
        p = dbl ? var_per : {var_per[14:0], 1'b0};
        case (mode)
            spmc_pkg::MODE_SHIFT: p = spmc_pkg::SHIFT_MODE_DIV;
            spmc_pkg::MODE_UART9_FIXED: p = dbl ? spmc_pkg::FIXED_MODE_DIV_FAST
                                                : spmc_pkg::FIXED_MODE_DIV_SLOW;
            default: p = p;
        endcase
        return p;
    endfunction

    function automatic spmc_state_s reset_state();
        spmc_state_s s;
        s = '0;
        s.rsp.awready = 1'b1;
        s.rsp.wready = 1'b1;
        s.rsp.arready = 1'b1;
        s.ctl = spmc_pkg::CONTROL_RST;
        s.power_control = spmc_pkg::POWER_CONTROL_RST;
        s.baud = spmc_pkg::BAUD_PERIOD_RST;
        s.tx_st = TX_IDLE;
        s.rx_st = RX_IDLE;
        s.rx_prev = 1'b1;
        s.txd = 1'b1;
        s.rxd_out = 1'b1;
        s.rxd_oe_n = 1'b1;
        return s;
    endfunction

    spmc_rx_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(rxd_in),
        .level_out(rx_lvl)
    );

    // ************************************************
    // Next-state logic
    // ************************************************
    always_comb begin
        logic [1:0] mode;
        logic m0;
        logic nine;
        logic fea;
        logic [15:0] per;
        logic [15:0] half;
        logic wr;
        logic tx_go;
        logic [7:0] tx_byte;
        logic [2:0] iclr;
        logic ti_set;
        logic ri_set;
        logic fe_set;
        logic [3:0] tx_last;
        logic [7:0] dat;
        logic nb;
        logic [7:0] rv;
        mode = {st_r.ctl[spmc_pkg::BIT_MODE_HIGH], st_r.ctl[spmc_pkg::BIT_MODE_LOW]};
        m0 = (mode == spmc_pkg::MODE_SHIFT);
        nine = mode[1];
        fea = st_r.power_control[spmc_pkg::BIT_FE_ACCESS_SELECT];
        per = bit_period(mode, st_r.power_control[spmc_pkg::BIT_BAUD_DOUBLER], st_r.baud);
        half = {1'b0, per[15:1]};
        wr = st_r.aw_got && st_r.w_got && !st_r.rsp.bvalid;
        tx_go = 1'b0;
        tx_byte = st_r.wdata[7:0];
        iclr = 3'h0;
        ti_set = 1'b0;
        ri_set = 1'b0;
        fe_set = 1'b0;
        tx_last = m0 ? 4'h7 : (nine ? 4'ha : 4'h9);
        dat = st_r.rx_sh;
        nb = 1'b0;
        rv = 8'h00;
        st_nxt = st_r;

        // ************************************************
        // Write channels
        // ************************************************
        if (axi_req.awvalid && st_r.rsp.awready) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.awaddr = axi_req.awaddr;
            st_nxt.rsp.awready = 1'b0;
        end
        if (axi_req.wvalid && st_r.rsp.wready) begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = axi_req.wdata;
            st_nxt.wstrb = axi_req.wstrb;
            st_nxt.rsp.wready = 1'b0;
        end
        if (wr) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.rsp.bvalid = 1'b1;
            st_nxt.rsp.bresp = spmc_pkg::RESP_OKAY;
            case (st_r.awaddr)
                spmc_pkg::OFS_SERIAL_CONTROL_STATUS: begin
                    if (st_r.wstrb[0]) begin
                        st_nxt.ctl = st_r.wdata[7:0];
                        if (fea) begin
                            // Top bit lands on the framing error flag instead of the mode bit
                            st_nxt.ctl[spmc_pkg::BIT_MODE_HIGH] = st_r.ctl[spmc_pkg::BIT_MODE_HIGH];
                            st_nxt.fe = st_r.wdata[7];
                        end
                    end
                end
                spmc_pkg::OFS_SERIAL_DATA_BUFFER: begin
                    tx_go = st_r.wstrb[0];
                end
                spmc_pkg::OFS_POWER_CONTROL: begin
                    if (st_r.wstrb[0]) begin
                        st_nxt.power_control = st_r.wdata[7:0] & spmc_pkg::POWER_CONTROL_MASK;
                    end
                end
                spmc_pkg::OFS_BAUD_PERIOD: begin
                    if (st_r.wstrb[0]) begin
                        st_nxt.baud[7:0] = st_r.wdata[7:0];
                    end
                    if (st_r.wstrb[1]) begin
                        st_nxt.baud[15:8] = st_r.wdata[15:8];
                    end
                end
                spmc_pkg::OFS_INT_STATUS: begin
                    st_nxt.rsp.bresp = spmc_pkg::RESP_OKAY;
                end
                spmc_pkg::OFS_INT_ENABLE: begin
                    if (st_r.wstrb[0]) begin
                        st_nxt.ien = st_r.wdata[2:0];
                    end
                end
                spmc_pkg::OFS_INT_CLEAR: begin
                    if (st_r.wstrb[0]) begin
                        iclr = st_r.wdata[2:0];
                    end
                end
                default: begin
                    st_nxt.rsp.bresp = spmc_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (st_r.rsp.bvalid && axi_req.bready) begin
            st_nxt.rsp.bvalid = 1'b0;
            st_nxt.rsp.awready = 1'b1;
            st_nxt.rsp.wready = 1'b1;
        end

        // ************************************************
        // Read channels
        // ************************************************
        if (axi_req.arvalid && st_r.rsp.arready) begin
            st_nxt.rsp.arready = 1'b0;
            st_nxt.rsp.rvalid = 1'b1;
            st_nxt.rsp.rresp = spmc_pkg::RESP_OKAY;
            st_nxt.rsp.rdata = 32'h0000_0000;
            case (axi_req.araddr)
                spmc_pkg::OFS_SERIAL_CONTROL_STATUS: begin
                    rv = st_r.ctl;
                    rv[spmc_pkg::BIT_MODE_HIGH] = fea ? st_r.fe : st_r.ctl[spmc_pkg::BIT_MODE_HIGH];
                    st_nxt.rsp.rdata[7:0] = rv;
                end
                spmc_pkg::OFS_SERIAL_DATA_BUFFER: st_nxt.rsp.rdata[7:0] = st_r.rx_buf;
                spmc_pkg::OFS_POWER_CONTROL: st_nxt.rsp.rdata[7:0] = st_r.power_control;
                spmc_pkg::OFS_BAUD_PERIOD: st_nxt.rsp.rdata[15:0] = st_r.baud;
                spmc_pkg::OFS_INT_STATUS: st_nxt.rsp.rdata[2:0] = st_r.istat;
                spmc_pkg::OFS_INT_ENABLE: st_nxt.rsp.rdata[2:0] = st_r.ien;
                spmc_pkg::OFS_INT_CLEAR: st_nxt.rsp.rdata[2:0] = 3'h0;
                default: st_nxt.rsp.rresp = spmc_pkg::RESP_SLVERR;
            endcase
        end
        if (st_r.rsp.rvalid && axi_req.rready) begin
            st_nxt.rsp.rvalid = 1'b0;
            st_nxt.rsp.arready = 1'b1;
        end

        // ************************************************
        // Transmit engine
        // ************************************************
        case (st_r.tx_st)
            TX_IDLE: begin
                // Shift mode shares the clock pin, so a running shift receive blocks the start
                if (tx_go && !(m0 && st_r.rx_st != RX_IDLE)) begin
                    st_nxt.tx_st = TX_SEND;
                    st_nxt.tx_idx = 4'h0;
                    st_nxt.tx_cyc = 16'h0000;
                    if (m0) begin
                        st_nxt.tx_sh = {3'h0, tx_byte};
                    end else begin
                        st_nxt.tx_sh = {1'b1, nine ? st_r.ctl[spmc_pkg::BIT_TRANSMIT_NINTH] : 1'b1,
                                        tx_byte, 1'b0};
                    end
                end
            end
            TX_SEND: begin
                if (st_r.tx_cyc == per - 16'h0001) begin
                    st_nxt.tx_cyc = 16'h0000;
                    if (st_r.tx_idx == tx_last) begin
                        st_nxt.tx_st = TX_IDLE;
                    end else begin
                        st_nxt.tx_idx = st_r.tx_idx + 4'h1;
                        st_nxt.tx_sh = {1'b0, st_r.tx_sh[10:1]};
                    end
                    if (m0 && st_r.tx_idx == 4'h7) begin
                        ti_set = 1'b1;
                    end
                    if (!m0 && st_r.tx_idx + 4'h1 == tx_last) begin
                        ti_set = 1'b1;
                    end
                end else begin
                    st_nxt.tx_cyc = st_r.tx_cyc + 16'h0001;
                end
            end
            default: st_nxt.tx_st = TX_IDLE;
        endcase

        // ************************************************
        // Receive engine
        // ************************************************
        st_nxt.rx_prev = rx_lvl;
        if (st_r.rx_idx < 4'h8) begin
            dat = {rx_lvl, st_r.rx_sh[7:1]};
        end
        case (st_r.rx_st)
            RX_IDLE: begin
                if (st_r.ctl[spmc_pkg::BIT_RECEIVE_ENABLE]) begin
                    if (m0) begin
                        if (!st_r.ctl[spmc_pkg::BIT_RECEIVE_DONE] && st_r.tx_st == TX_IDLE && !tx_go) begin
                            st_nxt.rx_st = RX_DATA;
                            st_nxt.rx_idx = 4'h0;
                            st_nxt.rx_cyc = 16'h0000;
                        end
                    end else if (st_r.rx_prev && !rx_lvl) begin
                        st_nxt.rx_st = RX_START;
                        st_nxt.rx_cyc = 16'h0000;
                    end
                end
            end
            RX_START: begin
                if (!st_r.ctl[spmc_pkg::BIT_RECEIVE_ENABLE]) begin
                    st_nxt.rx_st = RX_IDLE;
                end else if (st_r.rx_cyc == half - 16'h0001) begin
                    // A start bit gone by mid-bit is a glitch
                    st_nxt.rx_st = rx_lvl ? RX_IDLE : RX_DATA;
                    st_nxt.rx_idx = 4'h0;
                    st_nxt.rx_cyc = 16'h0000;
                end else begin
                    st_nxt.rx_cyc = st_r.rx_cyc + 16'h0001;
                end
            end
            RX_DATA: begin
                if (!st_r.ctl[spmc_pkg::BIT_RECEIVE_ENABLE]) begin
                    st_nxt.rx_st = RX_IDLE;
                end else if (st_r.rx_cyc == per - 16'h0001) begin
                    st_nxt.rx_cyc = 16'h0000;
                    st_nxt.rx_idx = st_r.rx_idx + 4'h1;
                    st_nxt.rx_sh = dat;
                    if (m0 && st_r.rx_idx == 4'h7) begin
                        st_nxt.rx_st = RX_IDLE;
                        st_nxt.rx_buf = dat;
                        ri_set = 1'b1;
                    end else if (nine && st_r.rx_idx == 4'h8) begin
                        st_nxt.rx_ninth = rx_lvl;
                    end else if (!m0 && st_r.rx_idx == (nine ? 4'h9 : 4'h8)) begin
                        st_nxt.rx_st = RX_IDLE;
                        fe_set = !rx_lvl;
                        nb = nine ? st_r.rx_ninth : rx_lvl;
                        // Unread byte still pending: the new one is dropped
                        if (!st_r.ctl[spmc_pkg::BIT_RECEIVE_DONE] &&
                            (!st_r.ctl[spmc_pkg::BIT_MULTIPROCESSOR] || nb)) begin
                            st_nxt.rx_buf = st_r.rx_sh;
                            st_nxt.ctl[spmc_pkg::BIT_RECEIVE_NINTH] = nb;
                            ri_set = 1'b1;
                        end
                    end
                end else begin
                    st_nxt.rx_cyc = st_r.rx_cyc + 16'h0001;
                end
            end
            default: st_nxt.rx_st = RX_IDLE;
        endcase

        // ************************************************
        // Flags and interrupt: hardware set wins over software clear
        // ************************************************
        if (ti_set) begin
            st_nxt.ctl[spmc_pkg::BIT_TRANSMIT_DONE] = 1'b1;
        end
        if (ri_set) begin
            st_nxt.ctl[spmc_pkg::BIT_RECEIVE_DONE] = 1'b1;
        end
        if (fe_set) begin
            st_nxt.fe = 1'b1;
        end
        st_nxt.istat = (st_r.istat & ~iclr) | {fe_set, ri_set, ti_set};
        st_nxt.irq = |(st_nxt.istat & st_nxt.ien);

        // ************************************************
        // Pins
        // ************************************************
        st_nxt.txd = 1'b1;
        st_nxt.rxd_out = 1'b1;
        st_nxt.rxd_oe_n = 1'b1;
        if (st_nxt.tx_st == TX_SEND && m0) begin
            st_nxt.txd = st_nxt.tx_cyc >= half;
            st_nxt.rxd_out = st_nxt.tx_sh[0];
            st_nxt.rxd_oe_n = 1'b0;
        end else if (st_nxt.rx_st == RX_DATA && m0) begin
            st_nxt.txd = st_nxt.rx_cyc >= half;
        end else if (st_nxt.tx_st == TX_SEND) begin
            st_nxt.txd = st_nxt.tx_sh[0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= reset_state();
        end else begin
            st_r <= st_nxt;
        end
    end

    assign axi_rsp = st_r.rsp;
    assign txd = st_r.txd;
    assign rxd_out = st_r.rxd_out;
    assign rxd_oe_n = st_r.rxd_oe_n;
    assign irq = st_r.irq;

endmodule // spmc_serial_port

//--- tb/spmc_station.sv
// Remote serial station driving frames onto the receive line
`timescale 1ns/1ps
module spmc_station (
    // Clock
    input wire logic aclk,
    // Line towards the device, idle high like a pulled-up line
    output logic line
);
    initial line = 1'b1;
    // Frame bits go out first bit first, each held for p clocks
    task automatic send(input int p, input int n, input logic [10:0] f);
        for (int i = 0; i < n; i++) begin
            @(posedge aclk);
            line <= f[i];
            repeat (p - 1) @(posedge aclk);
        end
        @(posedge aclk);
        line <= 1'b1;
        repeat (12) @(posedge aclk);
    endtask
endmodule // spmc_station

//--- tb/spmc_serial_port_sva.sv
// Bus and pin assertions of the serial port
`timescale 1ns/1ps
module spmc_serial_port_sva (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus and pins
    input wire spmc_pkg::spmc_axi_req_s axi_req,
    input wire spmc_pkg::spmc_axi_rsp_s axi_rsp,
    input wire logic rxd_in,
    input wire logic rxd_out,
    input wire logic rxd_oe_n,
    input wire logic txd,
    input wire logic irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_rst;
        $rose(aresetn) |-> txd && !irq && rxd_oe_n && !axi_rsp.bvalid && axi_rsp.arready;
    endproperty
    a_rst: assert property (p_rst) else $error("bad state after reset");
    property p_wr;
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready |=> !axi_rsp.bvalid ##1 axi_rsp.bvalid;
    endproperty
    a_wr: assert property (p_wr) else $error("write answer late");
    property p_awlow;
        axi_req.awvalid && axi_rsp.awready |=> !axi_rsp.awready [*2];
    endproperty
    a_awlow: assert property (p_awlow) else $error("awready back too early");
    property p_rd;
        axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid && !axi_rsp.arready;
    endproperty
    a_rd: assert property (p_rd) else $error("read answer late");
    property p_rerr;
        axi_req.arvalid && axi_rsp.arready && axi_req.araddr > 8'h18 |=> axi_rsp.rresp == 2'h2 && axi_rsp.rdata == 0;
    endproperty
    a_rerr: assert property (p_rerr) else $error("unmapped read not refused");
    property p_low;
        $fell(txd) |=> !txd [*2];
    endproperty
    a_low: assert property (p_low) else $error("start or clock low too short");
    property p_oe;
        rxd_oe_n |-> rxd_out;
    endproperty
    a_oe: assert property (p_oe) else $error("released pin value not high");
    property p_go;
        axi_req.awvalid && axi_rsp.awready && axi_req.awaddr == 8'h04 && txd && rxd_oe_n |-> ##[1:6] !txd;
    endproperty
    a_go: assert property (p_go) else $error("data write did not start transmit");
    c_wr: cover property (axi_rsp.bvalid && axi_req.bready);
    c_rd: cover property (axi_rsp.rvalid && axi_req.rready);
    c_tx: cover property ($fell(txd));
endmodule // spmc_serial_port_sva
bind spmc_serial_port spmc_serial_port_sva spmc_serial_port_sva_inst (.aclk(aclk), .aresetn(aresetn),
    .axi_req(axi_req), .axi_rsp(axi_rsp), .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n), .txd(txd), .irq(irq));

//--- tb/spmc_serial_port_tb.sv
// Register-level tests of the serial port
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module spmc_serial_port_tb;
    logic aclk, aresetn, line, rxd_out, rxd_oe_n, txd, irq;
    wire logic rxd_in;
    spmc_pkg::spmc_axi_req_s req;
    spmc_pkg::spmc_axi_rsp_s rsp;
    logic [31:0] rdat;
    logic [1:0] rres;
    int errors = 0;
    int samples_checked = 0;
    assign rxd_in = rxd_oe_n ? line : rxd_out;
    spmc_serial_port spmc_serial_port_inst (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
        .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n), .txd(txd), .irq(irq));
    spmc_station spmc_station_inst (.aclk(aclk), .line(line));
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (!rsp.bvalid);
        rres = rsp.bresp;
        req.bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (!rsp.rvalid);
        rdat = rsp.rdata;
        rres = rsp.rresp;
        req.rready <= 1'b0;
    endtask
    // Samples mid bit; a late start seen here is absorbed by the half-bit margin
    task automatic txcap(input int p, input int n, input logic [10:0] e);
        logic [10:0] f;
        f = '0;
        while (txd !== 1'b0) @(posedge aclk);
        repeat (p / 2) @(posedge aclk);
        for (int i = 0; i < n; i++) begin
            f[i] = txd;
            repeat (p) @(posedge aclk);
        end
        `CHK(f, e)
    endtask
    task automatic stop_test();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        errors++;
        stop_test();
    end
    initial begin
        logic [7:0] f;
        req = '0;
        aresetn = 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h00);
        `CHK(rdat, 32'h0)
        rd(8'h0c);
        `CHK(rdat, 32'ha0)
        rd(8'h40);
        `CHK(rres, 2'h2)
        wr(8'h40, 32'h0);
        `CHK(rres, 2'h2)
        wr(8'h04, 32'h5a);
        for (int i = 0; i < 8; i++) begin
            @(posedge txd);
            f[i] = rxd_out;
        end
        `CHK(f, 8'h5a)
        // Flag lands at the end of the eighth bit, a few clocks after its last clock rise
        repeat (4) @(posedge aclk);
        rd(8'h10);
        `CHK(rdat, 32'h1)
        `CHK(irq, 1'b0)
        wr(8'h14, 32'h7);
        rd(8'h00);
        `CHK(rdat, 32'h02)
        `CHK(irq, 1'b1)
        wr(8'h18, 32'h7);
        wr(8'h0c, 32'h4);
        wr(8'h00, 32'h40);
        `CHK(irq, 1'b0)
        wr(8'h04, 32'ha5);
        txcap(8, 10, {1'b1, 8'ha5, 1'b0});
        wr(8'h00, 32'h88);
        wr(8'h04, 32'h96);
        txcap(32, 11, {2'b11, 8'h96, 1'b0});
        wr(8'h00, 32'hf8);
        spmc_station_inst.send(8, 11, {2'b10, 8'h3c, 1'b0});
        rd(8'h00);
        `CHK(rdat[0], 1'b0)
        spmc_station_inst.send(8, 11, {2'b11, 8'hc3, 1'b0});
        rd(8'h00);
        `CHK(rdat[2:0], 3'h5)
        rd(8'h04);
        `CHK(rdat, 32'hc3)
        rd(8'h00);
        `CHK(rdat[0], 1'b1)
        wr(8'h00, 32'h70);
        wr(8'h08, 32'h40);
        spmc_station_inst.send(8, 10, {1'b0, 8'h55, 1'b0});
        rd(8'h00);
        `CHK(rdat & 32'hfb, 32'hf0)
        wr(8'h08, 32'h0);
        rd(8'h00);
        `CHK(rdat & 32'hfb, 32'h70)
        wr(8'h00, 32'h40);
        spmc_station_inst.send(8, 10, {1'b1, 8'h12, 1'b0});
        rd(8'h00);
        `CHK(rdat[0], 1'b0)
        wr(8'h00, 32'h50);
        spmc_station_inst.send(8, 10, {1'b1, 8'h12, 1'b0});
        rd(8'h00);
        `CHK(rdat, 32'h55)
        rd(8'h04);
        `CHK(rdat, 32'h12)
        stop_test();
    end
endmodule // spmc_serial_port_tb
